//--- ucs_pkg.sv
// constants and types of the serial control and status registers
package ucs_pkg;
	localparam logic [7:0] ADDR_CSA = 8'hc0;
	localparam logic [7:0] ADDR_CB  = 8'hc1;
	localparam logic [7:0] ADDR_CC  = 8'hc2;
	localparam logic [7:0] ADDR_DAT = 8'hc6;
	localparam logic [7:0] RST_CB   = 8'h00;
	localparam logic [7:0] RST_CC   = 8'h06;
	localparam int BIT_TXC  = 6;
	localparam int BIT_U2X  = 1;
	localparam int BIT_MPCM = 0;
	localparam int BIT_TX9  = 0;
	localparam int RXQ_DEPTH = 2;
	localparam logic [4:0] DIV_NORM = 5'h10;
	localparam logic [4:0] DIV_FAST = 5'h08;
	localparam logic [4:0] DIV_SYNC = 5'h02;
	localparam logic [1:0] MODE_ASYNC = 2'h0;
	localparam logic [1:0] MODE_SYNC  = 2'h1;
	localparam logic [1:0] MODE_SPI   = 2'h3;

	typedef enum logic [1:0] {
		UCS_ASYNC,
		UCS_SYNC,
		UCS_RSVD,
		UCS_SPI
	} ucs_mode_e;

	// one received character as the frame engine hands it over
	typedef struct packed {
		logic       valid;
		logic [8:0] data;
		logic       frame_err;
		logic       parity_err;
		logic       addr_mark;
	} ucs_rx_s;

	// buffered character with its status
	typedef struct packed {
		logic [8:0] data;
		logic       frame_err;
		logic       parity_err;
	} ucs_ent_s;

	// decoded settings for the frame engine
	typedef struct packed {
		ucs_mode_e  mode;
		logic       parity_on;
		logic       parity_odd;
		logic       two_stop;
		logic [3:0] char_bits;
		logic [4:0] baud_div;
		logic       multiproc_filter;
		logic       spi_data_order;
		logic       spi_clock_phase;
		logic       clock_polarity;
	} ucs_cfg_s;
endpackage

//--- ucs_regs.sv
// control and status registers with receive queue and tx buffer flag
`timescale 1ns/1ps
module ucs_regs (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	input  wire logic             global_irq_en,
	input  wire ucs_pkg::ucs_rx_s rx_in,
	input  wire logic             rx_start,
	input  wire logic             rx_shift_full,
	input  wire logic             tx_take,
	input  wire logic             tx_shift_busy,
	input  wire logic             tx_shift_done,
	input  wire logic             tx_irq_ack,
	output ucs_pkg::ucs_cfg_s     cfg,
	output logic      [8:0]       tx_word,
	output logic                  tx_word_valid,
	output logic                  rx_pin_override,
	output logic                  tx_pin_override,
	output logic                  irq_rx_done,
	output logic                  irq_tx_done,
	output logic                  irq_tx_empty
);

////////////////////////////////////////////////////////////////////////
	logic [7:0]        control_b;
	logic [7:0]        control_c_frame_format;
	logic              double_speed;
	logic              multiproc_filter;
	logic              tx_done_flag;
	logic              overrun_flag;
	logic              tx_buf_full;
	logic              tx_active;
	logic [1:0]        rx_count;
	logic              rx_head;
	ucs_pkg::ucs_ent_s rx_q [ucs_pkg::RXQ_DEPTH];
	ucs_pkg::ucs_ent_s head;
	logic              spi;
	logic              rx_en;
	logic              tx_en;
	logic              wr_csa;
	logic              wr_cb;
	logic              wr_cc;
	logic              wr_dat;
	logic              rd_dat;
	logic              push;
	logic              pop;
	logic              ovr_set;
	logic              txc_set;
	logic              addr_drop;
	logic              rx_done_flag;
	logic              tx_buffer_empty_flag;
	logic [7:0]        next_rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	assign wr_csa = reg_wr && hit(reg_addr, ucs_pkg::ADDR_CSA);
	assign wr_cb  = reg_wr && hit(reg_addr, ucs_pkg::ADDR_CB);
	assign wr_cc  = reg_wr && hit(reg_addr, ucs_pkg::ADDR_CC);
	assign wr_dat = reg_wr && hit(reg_addr, ucs_pkg::ADDR_DAT);
	assign rd_dat = reg_rd && hit(reg_addr, ucs_pkg::ADDR_DAT);

	assign rx_en = control_b[4];
	assign tx_en = control_b[3];
	assign spi = control_c_frame_format[7:6] == ucs_pkg::MODE_SPI;
	assign head = rx_q[rx_head];

////////////////////////////////////////////////////////////////////////
// configuration registers

	always_ff @(posedge clk) begin
		if (!rst_n)
			control_c_frame_format <= ucs_pkg::RST_CC;
		else if (wr_cc)
			control_c_frame_format <= reg_wdata;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			control_b <= ucs_pkg::RST_CB;
		else if (wr_cb)
			control_b <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
	end

	// error bits of a write are ignored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			double_speed     <= 1'b0;
			multiproc_filter <= 1'b0;
		end else if (wr_csa) begin
			double_speed     <= reg_wdata[ucs_pkg::BIT_U2X];
			multiproc_filter <= reg_wdata[ucs_pkg::BIT_MPCM];
		end
	end

////////////////////////////////////////////////////////////////////////
// decoded settings

	always_comb begin
		cfg = '0;
		cfg.mode = ucs_pkg::ucs_mode_e'(control_c_frame_format[7:6]);
		cfg.parity_on  = !spi && control_c_frame_format[5];
		cfg.parity_odd = !spi && control_c_frame_format[4];
		cfg.two_stop   = !spi && control_c_frame_format[3];
		case ({control_b[2], control_c_frame_format[2:1]})
			3'h0: cfg.char_bits = 4'h5;
			3'h1: cfg.char_bits = 4'h6;
			3'h2: cfg.char_bits = 4'h7;
			3'h7: cfg.char_bits = 4'h9;
			default: cfg.char_bits = 4'h8;
		endcase
		// spi frames are always eight bits
		if (spi)
			cfg.char_bits = 4'h8;
		if (control_c_frame_format[7:6] == ucs_pkg::MODE_ASYNC)
			cfg.baud_div = double_speed ? ucs_pkg::DIV_FAST
			                            : ucs_pkg::DIV_NORM;
		else
			cfg.baud_div = ucs_pkg::DIV_SYNC;
		cfg.multiproc_filter = !spi && multiproc_filter;
		cfg.spi_data_order  = spi && control_c_frame_format[2];
		cfg.spi_clock_phase = spi && control_c_frame_format[1];
		cfg.clock_polarity  = control_c_frame_format[0];
	end

////////////////////////////////////////////////////////////////////////
// receive queue

	assign addr_drop = cfg.multiproc_filter && !rx_in.addr_mark;
	assign push = rx_in.valid && rx_en && !addr_drop &&
	              rx_count != 2'(ucs_pkg::RXQ_DEPTH);
	assign pop  = rd_dat && rx_count != 2'h0;

	always_ff @(posedge clk) begin
		if (push) begin
			rx_q[rx_head ^ rx_count[0]].data      <= rx_in.data;
			rx_q[rx_head ^ rx_count[0]].frame_err <= rx_in.frame_err;
			rx_q[rx_head ^ rx_count[0]].parity_err <=
				rx_in.parity_err && control_c_frame_format[5];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en) begin
			rx_count <= 2'h0;
			rx_head  <= 1'b0;
		end else begin
			rx_count <= rx_count + 2'(push) - 2'(pop);
			if (pop)
				rx_head <= !rx_head;
		end
	end

	assign ovr_set = rx_en && rx_start && rx_shift_full &&
	                 rx_count == 2'(ucs_pkg::RXQ_DEPTH);

	// set wins over the clear by read
	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en)
			overrun_flag <= 1'b0;
		else if (ovr_set)
			overrun_flag <= 1'b1;
		else if (pop)
			overrun_flag <= 1'b0;
	end

	assign rx_done_flag    = rx_count != 2'h0;
	assign rx_pin_override = rx_en;

////////////////////////////////////////////////////////////////////////
// transmit side

	// ninth bit taken with low byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_buf_full <= 1'b0;
			tx_word     <= 9'h000;
		end else if (wr_dat && !tx_buf_full) begin
			tx_buf_full <= 1'b1;
			tx_word     <= {control_b[ucs_pkg::BIT_TX9], reg_wdata};
		end else if (tx_take) begin
			tx_buf_full <= 1'b0;
		end
	end

	assign tx_buffer_empty_flag = !tx_buf_full;
	assign tx_word_valid        = tx_buf_full && tx_active;

	always_ff @(posedge clk) begin
		if (!rst_n)
			tx_active <= 1'b0;
		else
			tx_active <= tx_en || tx_buf_full || tx_shift_busy;
	end

	assign tx_pin_override = tx_active;

	assign txc_set = tx_shift_done && !tx_buf_full;

	always_ff @(posedge clk) begin
		if (!rst_n)
			tx_done_flag <= 1'b0;
		else if (txc_set)
			tx_done_flag <= 1'b1;
		else if (tx_irq_ack || (wr_csa && reg_wdata[ucs_pkg::BIT_TXC]))
			tx_done_flag <= 1'b0;
	end

////////////////////////////////////////////////////////////////////////
// interrupts and read port

	assign irq_rx_done  = control_b[7] && global_irq_en && rx_done_flag;
	assign irq_tx_done  = control_b[6] && global_irq_en && tx_done_flag;
	assign irq_tx_empty = control_b[5] && global_irq_en &&
	                      tx_buffer_empty_flag;

	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ucs_pkg::ADDR_CSA: begin
				next_rdata = {rx_done_flag, tx_done_flag,
				              tx_buffer_empty_flag, 5'h00};
				if (!spi && rx_done_flag)
					next_rdata[4:2] = {head.frame_err, overrun_flag,
					                   head.parity_err};
				else if (!spi)
					next_rdata[3] = overrun_flag;
				if (!spi)
					next_rdata[1:0] = {double_speed, multiproc_filter};
			end
			ucs_pkg::ADDR_CB: begin
				next_rdata = control_b;
				next_rdata[1] = !spi && rx_done_flag && head.data[8];
				if (spi) begin
					next_rdata[2] = 1'b0;
					next_rdata[0] = 1'b0;
				end
			end
			ucs_pkg::ADDR_CC: next_rdata = control_c_frame_format;
			ucs_pkg::ADDR_DAT:
				next_rdata = rx_done_flag ? head.data[7:0] : 8'h00;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 8'h00;
	end

////////////////////////////////////////////////////////////////////////
// checks

	property p_empty_clears;
		@(posedge clk) disable iff (!rst_n)
		wr_dat && !tx_buf_full |=> !tx_buffer_empty_flag;
	endproperty
	a_empty_clears: assert property (p_empty_clears)
		else $error("empty flag not cleared by accepted write");

	property p_frame_err;
		@(posedge clk) disable iff (!rst_n)
		push && rx_count == 2'h0 |=> head.frame_err == $past(rx_in.frame_err);
	endproperty
	a_frame_err: assert property (p_frame_err)
		else $error("framing status not stored with character");

	property p_overrun;
		@(posedge clk) disable iff (!rst_n)
		ovr_set |=> overrun_flag;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

	property p_parity_off;
		@(posedge clk) disable iff (!rst_n)
		push && rx_count == 2'h0 && !control_c_frame_format[5]
			|=> !head.parity_err;
	endproperty
	a_parity_off: assert property (p_parity_off)
		else $error("parity error stored while checking off");

	property p_fast_div;
		@(posedge clk) disable iff (!rst_n)
		cfg.mode == ucs_pkg::UCS_ASYNC && double_speed
			|-> cfg.baud_div == ucs_pkg::DIV_FAST;
	endproperty
	a_fast_div: assert property (p_fast_div)
		else $error("double speed divider wrong");

	property p_mp_drop;
		@(posedge clk) disable iff (!rst_n)
		rx_in.valid && cfg.multiproc_filter && !rx_in.addr_mark
			&& !pop |=> rx_count == $past(rx_count);
	endproperty
	a_mp_drop: assert property (p_mp_drop)
		else $error("unaddressed frame entered queue");

	property p_irq_gate;
		@(posedge clk) disable iff (!rst_n)
		irq_rx_done |-> control_b[7] && global_irq_en && rx_count != 2'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("receive interrupt without its conditions");

	property p_flush;
		@(posedge clk) disable iff (!rst_n)
		!rx_en |=> rx_count == 2'h0 && !overrun_flag;
	endproperty
	a_flush: assert property (p_flush)
		else $error("receiver disable did not flush");

	property p_drain;
		@(posedge clk) disable iff (!rst_n)
		!tx_en && (tx_buf_full || tx_shift_busy) |=> tx_pin_override;
	endproperty
	a_drain: assert property (p_drain)
		else $error("transmitter released pin before draining");

	property p_txc_set;
		@(posedge clk) disable iff (!rst_n)
		txc_set |=> tx_done_flag;
	endproperty
	a_txc_set: assert property (p_txc_set)
		else $error("tx done flag not set");

endmodule

//--- ucs_node_model.sv
// frame engine stand-in on the serial side of the registers
`timescale 1ns/1ps
module ucs_node_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        tx_word_valid,
	output ucs_pkg::ucs_rx_s rx_in,
	output logic             rx_start,
	output logic             rx_shift_full,
	output logic             tx_take,
	output logic             tx_shift_busy,
	output logic             tx_shift_done
);
	logic [5:0] left;

	initial begin
		rx_in = '0;
		rx_start = 1'b0;
		rx_shift_full = 1'b0;
		tx_take = 1'b0;
		tx_shift_busy = 1'b0;
		tx_shift_done = 1'b0;
		left = '0;
	end

	////////////////////////////////////////////////////////////////////
	// shifter stays busy 5 cycles per word, 41 when slow
	always @(posedge clk) begin
		tx_take <= 1'b0;
		tx_shift_done <= 1'b0;
		if (!rst_n) begin
			tx_shift_busy <= 1'b0;
		end else if (tx_shift_busy) begin
			left <= left - 6'h01;
			if (left == 6'h00) begin
				tx_shift_busy <= 1'b0;
				tx_shift_done <= 1'b1;
			end
		end else if (tx_word_valid) begin
			tx_take <= 1'b1;
			tx_shift_busy <= 1'b1;
			left <= slow ? 6'h28 : 6'h04;
		end
	end

	// data inverted after the pulse so a stale value never matches
	task automatic send_char(input logic [8:0] d, input logic fe,
			input logic pe, input logic mark);
		@(posedge clk);
		rx_in <= '{1'b1, d, fe, pe, mark};
		@(posedge clk);
		rx_in <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
	endtask

	task automatic start_over();
		@(posedge clk);
		rx_shift_full <= 1'b1;
		rx_start <= 1'b1;
		@(posedge clk);
		rx_shift_full <= 1'b0;
		rx_start <= 1'b0;
	endtask
endmodule

//--- ucs_regs_tb.sv
// self-checking bench for the serial control and status registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module ucs_regs_tb;
	logic clk, rst_n, reg_wr, reg_rd, global_irq_en, slow, tx_irq_ack;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
	logic [8:0] tx_word;
	logic rx_start, rx_shift_full, tx_take, tx_shift_busy, tx_shift_done;
	logic tx_word_valid, rx_pin_override, tx_pin_override;
	logic irq_rx_done, irq_tx_done, irq_tx_empty;
	ucs_pkg::ucs_rx_s  rx_in;
	ucs_pkg::ucs_cfg_s cfg;
	int mismatches = 0;
	int checked = 0;

	ucs_regs ucs_regs_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
		.rx_in(rx_in), .rx_start(rx_start), .rx_shift_full(rx_shift_full),
		.tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
		.tx_shift_done(tx_shift_done), .tx_irq_ack(tx_irq_ack), .cfg(cfg),
		.tx_word(tx_word), .tx_word_valid(tx_word_valid),
		.rx_pin_override(rx_pin_override),
		.tx_pin_override(tx_pin_override), .irq_rx_done(irq_rx_done),
		.irq_tx_done(irq_tx_done), .irq_tx_empty(irq_tx_empty));
	ucs_node_model ucs_node_model_inst (.clk(clk), .rst_n(rst_n),
		.slow(slow), .tx_word_valid(tx_word_valid), .rx_in(rx_in),
		.rx_start(rx_start), .rx_shift_full(rx_shift_full),
		.tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
		.tx_shift_done(tx_shift_done));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask

	task automatic t_reset();
		rd(ucs_pkg::ADDR_CSA);
		`CHK("status", 8'h20, rd_v)
		rd(ucs_pkg::ADDR_CB);
		`CHK("control_b", ucs_pkg::RST_CB, rd_v)
		rd(ucs_pkg::ADDR_CC);
		`CHK("control_c", ucs_pkg::RST_CC, rd_v)
		rd(8'hc3);
		`CHK("unmapped", 8'h00, rd_v)
		`CHK("div", ucs_pkg::DIV_NORM, cfg.baud_div)
		// read-only bits 7 and 5 written high
		// error bits written zero
		wr(ucs_pkg::ADDR_CSA, 8'ha3);
		`CHK("fast_div", ucs_pkg::DIV_FAST, cfg.baud_div)
		`CHK("filter", 1'b1, cfg.multiproc_filter)
		rd(ucs_pkg::ADDR_CSA);
		`CHK("status_rw", 8'h23, rd_v)
		wr(ucs_pkg::ADDR_CSA, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_cfg();
		logic [7:0] cc [5];
		logic [6:0] ex [5];
		logic [6:0] fr;
		cc = '{8'h00, 8'h22, 8'h34, 8'h0e, 8'h06};
		ex = '{7'h05, 7'h46, 7'h67, 7'h18, 7'h09};
		for (int i = 0; i < 5; i++) begin
			wr(ucs_pkg::ADDR_CB, (i == 4) ? 8'h04 : 8'h00);
			wr(ucs_pkg::ADDR_CC, cc[i]);
			fr = {cfg.parity_on, cfg.parity_odd, cfg.two_stop, cfg.char_bits};
			`CHK("frame", ex[i], fr)
		end
		wr(ucs_pkg::ADDR_CC, 8'h46);
		`CHK("sync", ucs_pkg::UCS_SYNC, cfg.mode)
		`CHK("sync_div", ucs_pkg::DIV_SYNC, cfg.baud_div)
		wr(ucs_pkg::ADDR_CC, 8'hc5);
		`CHK("spi", ucs_pkg::UCS_SPI, cfg.mode)
		`CHK("order", 1'b1, cfg.spi_data_order)
		`CHK("polarity", 1'b1, cfg.clock_polarity)
		`CHK("spi_bits", 4'h8, cfg.char_bits)
		rd(ucs_pkg::ADDR_CB);
		`CHK("spi_cb", 8'h00, rd_v)
		wr(ucs_pkg::ADDR_CC, 8'hc2);
		fr = {5'h00, cfg.spi_data_order, cfg.spi_clock_phase};
		`CHK("phase", 7'h01, fr)
		wr(ucs_pkg::ADDR_CC, 8'h86);
		`CHK("rsvd", ucs_pkg::UCS_RSVD, cfg.mode)
		wr(ucs_pkg::ADDR_CC, 8'h06);
		$display("test cfg done");
	endtask

	task automatic t_rx();
		@(posedge clk);
		global_irq_en <= 1'b1;
		wr(ucs_pkg::ADDR_CB, 8'h94);
		`CHK("rx_pin", 1'b1, rx_pin_override)
		// parity off when first char lands
		ucs_node_model_inst.send_char(9'h1a5, 1'b1, 1'b1, 1'b0);
		wr(ucs_pkg::ADDR_CC, 8'h26);
		ucs_node_model_inst.send_char(9'h03c, 1'b0, 1'b1, 1'b0);
		ucs_node_model_inst.send_char(9'h0ff, 1'b0, 1'b0, 1'b0);
		ucs_node_model_inst.start_over();
		rd(ucs_pkg::ADDR_CSA);
		`CHK("head_a", 8'hb8, rd_v)
		`CHK("irq_rx", 1'b1, irq_rx_done)
		rd(ucs_pkg::ADDR_CB);
		`CHK("ninth_a", 1'b1, rd_v[1])
		rd(ucs_pkg::ADDR_DAT);
		`CHK("data_a", 8'ha5, rd_v)
		rd(ucs_pkg::ADDR_CSA);
		`CHK("head_b", 8'ha4, rd_v)
		rd(ucs_pkg::ADDR_CB);
		`CHK("ninth_b", 1'b0, rd_v[1])
		rd(ucs_pkg::ADDR_DAT);
		`CHK("data_b", 8'h3c, rd_v)
		rd(ucs_pkg::ADDR_CSA);
		`CHK("empty", 8'h20, rd_v)
		`CHK("irq_rx_off", 1'b0, irq_rx_done)
		wr(ucs_pkg::ADDR_CSA, 8'h01);
		ucs_node_model_inst.send_char(9'h011, 1'b0, 1'b0, 1'b0);
		ucs_node_model_inst.send_char(9'h022, 1'b0, 1'b0, 1'b1);
		rd(ucs_pkg::ADDR_DAT);
		`CHK("marked", 8'h22, rd_v)
		wr(ucs_pkg::ADDR_CSA, 8'h00);
		ucs_node_model_inst.send_char(9'h055, 1'b1, 1'b1, 1'b0);
		wr(ucs_pkg::ADDR_CB, 8'h00);
		rd(ucs_pkg::ADDR_CSA);
		`CHK("flushed", 8'h20, rd_v)
		`CHK("rx_pin_off", 1'b0, rx_pin_override)
		$display("test rx done");
	endtask

	task automatic t_tx();
		wr(ucs_pkg::ADDR_CB, 8'h69);
		`CHK("irq_empty", 1'b1, irq_tx_empty)
		wr(ucs_pkg::ADDR_DAT, 8'h5a);
		`CHK("tx_word", 9'h15a, tx_word)
		`CHK("irq_full", 1'b0, irq_tx_empty)
		`CHK("tx_pin", 1'b1, tx_pin_override)
		`CHK("tx_valid", 1'b1, tx_word_valid)
		for (int i = 0; i < 200 && irq_tx_done !== 1'b1; i++) @(posedge clk);
		rd(ucs_pkg::ADDR_CSA);
		`CHK("tx_done", 8'h60, rd_v)
		@(posedge clk);
		tx_irq_ack <= 1'b1;
		@(posedge clk);
		tx_irq_ack <= 1'b0;
		#1;
		`CHK("ack", 1'b0, irq_tx_done)
		@(posedge clk);
		global_irq_en <= 1'b0;
		#1;
		`CHK("global_off", 1'b0, irq_tx_empty)
		// disable while a slow frame is still shifting
		slow <= 1'b1;
		wr(ucs_pkg::ADDR_DAT, 8'hc3);
		wr(ucs_pkg::ADDR_CB, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		`CHK("held", 1'b1, tx_pin_override)
		for (int i = 0; i < 200 && tx_pin_override === 1'b1; i++) @(posedge clk);
		#1;
		`CHK("shift_idle", 1'b0, tx_shift_busy)
		`CHK("tx_pin_off", 1'b0, tx_pin_override)
		wr(ucs_pkg::ADDR_CSA, 8'h40);
		rd(ucs_pkg::ADDR_CSA);
		`CHK("tx_clear", 8'h20, rd_v)
		$display("test tx done");
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		mismatches++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		global_irq_en = 1'b0;
		slow = 1'b0;
		tx_irq_ack = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_cfg();
		t_rx();
		t_tx();
		end_of_test();
	end
endmodule
